//--- pkg/fcx_pkg.sv
// Purpose: Constants and types for the flash command, state gate and execute-in-place control
// Assumes: Serial link sampled by CLK_SYS; command codes below are chosen values
// Notes: Operation list follows
package fcx_pkg;

   localparam logic [7:0] OP_ACTIVATE = 8'h9b;
   localparam logic [7:0] SUB_CRC = 8'h27;
   localparam logic [7:0] OPT_RANGE = 8'hfe;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0b;
   localparam logic [7:0] OP_FAST_DUAL = 8'hbb;
   localparam logic [7:0] OP_FAST_QUAD = 8'heb;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_READ_FLAGS = 8'h70;
   localparam logic [7:0] OP_PROGRAM = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
   localparam logic [7:0] OP_SUBSECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_WRITE_NVCFG = 8'hb1;
   localparam logic [7:0] OP_PROGRAM_OTP = 8'h42;
   localparam logic [7:0] OP_DIE_ERASE = 8'hc4;
   localparam logic [7:0] OP_WRITE_VCFG = 8'h81;
   localparam logic [7:0] OP_WRITE_EVCFG = 8'h61;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_CLEAR_FLAGS = 8'h50;
   localparam logic [7:0] OP_WRITE_EXTADDR = 8'hc5;
   localparam logic [7:0] OP_WRITE_LOCK = 8'he5;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;

   localparam logic [4:0] CRC_SEQ_LEN = 5'h13;
   localparam logic [4:0] CRC_EXP_FIRST = 5'h03;
   localparam logic [4:0] CRC_START_FIRST = 5'h0b;
   localparam logic [4:0] CRC_END_FIRST = 5'h0f;
   localparam logic [4:0] ADDR_BYTES = 5'h03;
   localparam int VCR_XIP_BIT = 3;
   localparam logic [2:0] NVCR_XIP_OFF = 3'h7;
   localparam int SECTOR_LSB = 16;
   localparam int FLAG_ADDR_BIT = 1;
   localparam int FLAG_CRC_BIT = 4;

   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_BUSY = 2'b01,
      ST_SUSPEND_SMALL = 2'b10,
      ST_SUSPEND_ERASE = 2'b11
   } fcx_state_e;

   typedef enum logic [3:0] {
      CL_NONE = 4'b0000,
      CL_READ = 4'b0001,
      CL_READ_REG = 4'b0010,
      CL_PROGRAM = 4'b0011,
      CL_ERASE = 4'b0100,
      CL_WRITE_NV = 4'b0101,
      CL_WRITE_V = 4'b0110,
      CL_SUSPEND = 4'b0111,
      CL_RESUME = 4'b1000,
      CL_CRC = 4'b1001
   } fcx_class_e;

   typedef enum logic [1:0] {
      W_SINGLE = 2'b00,
      W_DUAL = 2'b01,
      W_QUAD = 2'b10
   } fcx_width_e;

   typedef struct packed {
      logic [63:0] expect_crc;
      logic [31:0] start_addr;
      logic [31:0] end_addr;
   } fcx_crc_req_s;

endpackage

//--- hdl/fcx_ctrl.sv
// Purpose: Command decode, device state gate, range check capture and execute-in-place control
// Assumes: Serial clock, select, data lines and reset pin come from outside CLK_SYS
// Notes: Check arithmetic and array timing live outside; results return on ports
`timescale 1ns/1ps
`default_nettype none

module fcx_ctrl (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic [3:0] DQ_IN,
   input wire logic RESET_PIN_N,
   input wire logic RESET_PIN_EN,
   input wire logic BASIC_XIP,
   input wire logic [2:0] NVCR_XIP_CFG,
   input wire fcx_pkg::fcx_width_e PROTO_WIDTH,
   input wire logic OP_DONE,
   input wire logic CRC_DONE,
   input wire logic [63:0] CRC_RESULT,
   output logic CMD_ACCEPT,
   output logic CMD_REJECT,
   output fcx_pkg::fcx_class_e CMD_CLASS,
   output logic [7:0] CMD_OPCODE,
   output logic [23:0] CMD_ADDR,
   output logic READ_UNSAFE,
   output fcx_pkg::fcx_state_e DEV_STATE,
   output logic XIP_ACTIVE,
   output logic VCR_XIP_N,
   output logic CRC_START,
   output fcx_pkg::fcx_crc_req_s CRC_REQ,
   output logic CRC_BUSY,
   output logic FLAG_ADDR_ERR,
   output logic FLAG_CRC_ERR
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [7:0] sync1;
   logic [7:0] sync2;
   logic sck_d;
   logic cs_d;
   logic sck_rise;
   logic cs_rise;
   logic cs_fall;
   logic [3:0] dq;
   logic cs_low;
   logic rst_pin_n;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         sync1 <= 8'hff;
         sync2 <= 8'hff;
         sck_d <= 1'b0;
         cs_d <= 1'b1;
      end else if (CE) begin
         sync1 <= {RESET_PIN_N, DQ_IN, CS_N, SCK, 1'b1};
         sync2 <= sync1;
         sck_d <= sync2[1];
         cs_d <= sync2[2];
      end
   end

   assign dq = sync2[6:3];
   assign rst_pin_n = sync2[7];
   assign cs_low = !sync2[2];
   assign sck_rise = CE && sync2[1] && !sck_d && cs_low;
   assign cs_rise = CE && sync2[2] && !cs_d;
   assign cs_fall = CE && !sync2[2] && cs_d;

   // ****************************************************************
   // Bit and byte assembly
   // ****************************************************************
   logic [7:0] shreg;
   logic [3:0] bit_cnt;
   logic [4:0] byte_cnt;
   logic [7:0] opcode;
   logic [23:0] addr;
   logic [7:0] data0;
   logic [3:0] step;
   logic [3:0] next_bits;
   logic [7:0] next_byte;
   logic byte_done;
   logic xip_frame;
   logic fast_frame;
   logic [4:0] addr_end;
   logic dummy_pending;
   logic confirm_now;
   logic crc_ok;
   logic xip_active;
   logic vcr_xip_n;
   logic reset_fire;

   always_comb begin
      case (PROTO_WIDTH)
         fcx_pkg::W_DUAL: begin
            step = 4'h2;
            next_byte = {shreg[5:0], dq[1:0]};
         end
         fcx_pkg::W_QUAD: begin
            step = 4'h4;
            next_byte = {shreg[3:0], dq[3:0]};
         end
         default: begin
            step = 4'h1;
            next_byte = {shreg[6:0], dq[0]};
         end
      endcase
      next_bits = bit_cnt + step;
      byte_done = sck_rise && !dummy_pending && (next_bits == 4'h8);
   end

   // Address-only frames while in execute-in-place
   assign addr_end = xip_frame ? fcx_pkg::ADDR_BYTES : fcx_pkg::ADDR_BYTES + 5'h01;
   assign fast_frame = xip_frame || (opcode == fcx_pkg::OP_FAST_READ)
      || (opcode == fcx_pkg::OP_FAST_DUAL) || (opcode == fcx_pkg::OP_FAST_QUAD);
   // First dummy clock takes line 0 only; the upper lines are not looked at
   assign confirm_now = sck_rise && dummy_pending;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         shreg <= 8'h00;
         bit_cnt <= 4'h0;
         byte_cnt <= 5'h00;
         xip_frame <= 1'b0;
      end else if (CE) begin
         if (cs_fall) begin
            bit_cnt <= 4'h0;
            byte_cnt <= 5'h00;
            xip_frame <= xip_active;
         end else if (sck_rise && !dummy_pending) begin
            shreg <= next_byte;
            if (byte_done) begin
               bit_cnt <= 4'h0;
               if (byte_cnt != 5'h1f) begin
                  byte_cnt <= byte_cnt + 5'h01;
               end
            end else begin
               bit_cnt <= next_bits;
            end
         end
      end
   end

   // Opcode, address and first data byte capture
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         opcode <= 8'h00;
         addr <= 24'h000000;
         data0 <= 8'h00;
      end else if (CE) begin
         if (cs_fall) begin
            opcode <= xip_active ? fcx_pkg::OP_FAST_READ : 8'h00;
         end else if (byte_done) begin
            if (byte_cnt == 5'h00 && !xip_frame) begin
               opcode <= next_byte;
            end else if (byte_cnt < addr_end) begin
               addr <= {addr[15:0], next_byte};
            end
            if (byte_cnt == 5'h01) begin
               data0 <= next_byte;
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         dummy_pending <= 1'b0;
      end else if (CE) begin
         if (cs_fall || cs_rise) begin
            dummy_pending <= 1'b0;
         end else if (byte_done && fast_frame && (byte_cnt + 5'h01 == addr_end)) begin
            dummy_pending <= 1'b1;
         end else if (confirm_now) begin
            dummy_pending <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Range check sequence
   // ****************************************************************
   fcx_pkg::fcx_crc_req_s req;
   logic [5:0] exp_lsb;
   logic [4:0] start_lsb;
   logic [4:0] end_lsb;
   logic crc_busy;

   assign exp_lsb = {byte_cnt[2:0] - fcx_pkg::CRC_EXP_FIRST[2:0], 3'b000};
   assign start_lsb = {byte_cnt[1:0] - fcx_pkg::CRC_START_FIRST[1:0], 3'b000};
   assign end_lsb = {byte_cnt[1:0] - fcx_pkg::CRC_END_FIRST[1:0], 3'b000};

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         crc_ok <= 1'b0;
         req <= '0;
      end else if (CE) begin
         if (cs_fall) begin
            crc_ok <= 1'b1;
         end else if (byte_done && !xip_frame) begin
            case (byte_cnt)
               5'h00: if (next_byte != fcx_pkg::OP_ACTIVATE) crc_ok <= 1'b0;
               5'h01: if (next_byte != fcx_pkg::SUB_CRC) crc_ok <= 1'b0;
               5'h02: if (next_byte != fcx_pkg::OPT_RANGE) crc_ok <= 1'b0;
               default: begin
                  if (byte_cnt < fcx_pkg::CRC_START_FIRST) begin
                     req.expect_crc[exp_lsb +: 8] <= next_byte;
                  end else if (byte_cnt < fcx_pkg::CRC_END_FIRST) begin
                     req.start_addr[start_lsb +: 8] <= next_byte;
                  end else if (byte_cnt < fcx_pkg::CRC_SEQ_LEN) begin
                     req.end_addr[end_lsb +: 8] <= next_byte;
                  end
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Command classification and state gate
   // ****************************************************************
   fcx_pkg::fcx_class_e cls;
   fcx_pkg::fcx_state_e state;
   logic [7:0] susp_sector;
   logic busy_is_erase;
   logic allow;
   logic in_susp_sector;
   logic frame_end;
   logic decide;

   always_comb begin
      case (opcode)
         fcx_pkg::OP_READ, fcx_pkg::OP_FAST_READ, fcx_pkg::OP_FAST_DUAL,
         fcx_pkg::OP_FAST_QUAD: cls = fcx_pkg::CL_READ;
         fcx_pkg::OP_READ_STATUS, fcx_pkg::OP_READ_FLAGS: cls = fcx_pkg::CL_READ_REG;
         fcx_pkg::OP_PROGRAM: cls = fcx_pkg::CL_PROGRAM;
         fcx_pkg::OP_SECTOR_ERASE, fcx_pkg::OP_SUBSECTOR_ERASE: cls = fcx_pkg::CL_ERASE;
         fcx_pkg::OP_WRITE_STATUS, fcx_pkg::OP_WRITE_NVCFG, fcx_pkg::OP_DIE_ERASE:
            cls = fcx_pkg::CL_WRITE_NV;
         fcx_pkg::OP_PROGRAM_OTP: cls = fcx_pkg::CL_WRITE_NV;
         fcx_pkg::OP_WRITE_VCFG, fcx_pkg::OP_WRITE_EVCFG, fcx_pkg::OP_WRITE_ENABLE,
         fcx_pkg::OP_WRITE_DISABLE, fcx_pkg::OP_CLEAR_FLAGS, fcx_pkg::OP_WRITE_EXTADDR,
         fcx_pkg::OP_WRITE_LOCK: cls = fcx_pkg::CL_WRITE_V;
         fcx_pkg::OP_SUSPEND: cls = fcx_pkg::CL_SUSPEND;
         fcx_pkg::OP_RESUME: cls = fcx_pkg::CL_RESUME;
         fcx_pkg::OP_ACTIVATE: cls = fcx_pkg::CL_CRC;
         default: cls = fcx_pkg::CL_NONE;
      endcase
   end

   assign in_susp_sector = (addr[23:fcx_pkg::SECTOR_LSB] == susp_sector);
   assign frame_end = cs_rise && (byte_cnt != 5'h00);
   assign decide = frame_end && !xip_frame;

   always_comb begin
      case (cls)
         fcx_pkg::CL_READ: allow = (state != fcx_pkg::ST_BUSY);
         fcx_pkg::CL_READ_REG: allow = 1'b1;
         fcx_pkg::CL_PROGRAM: allow = (state == fcx_pkg::ST_STANDBY)
            || (state == fcx_pkg::ST_SUSPEND_ERASE && !in_susp_sector);
         fcx_pkg::CL_ERASE: allow = (state == fcx_pkg::ST_STANDBY);
         fcx_pkg::CL_WRITE_NV: allow = (state == fcx_pkg::ST_STANDBY);
         fcx_pkg::CL_WRITE_V: allow = (state != fcx_pkg::ST_BUSY);
         fcx_pkg::CL_SUSPEND: allow = (state == fcx_pkg::ST_BUSY);
         fcx_pkg::CL_RESUME: allow = (state == fcx_pkg::ST_SUSPEND_SMALL)
            || (state == fcx_pkg::ST_SUSPEND_ERASE);
         fcx_pkg::CL_CRC: allow = crc_ok && (byte_cnt == fcx_pkg::CRC_SEQ_LEN) && !crc_busy;
         default: allow = 1'b0;
      endcase
   end

   // One state register holds the single device state; permissions above use it device-wide, with a sector match only for program in erase suspend
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state <= fcx_pkg::ST_STANDBY;
         busy_is_erase <= 1'b0;
         susp_sector <= 8'h00;
      end else if (CE) begin
         case (state)
            fcx_pkg::ST_STANDBY: begin
               if (decide && allow && (cls == fcx_pkg::CL_PROGRAM || cls == fcx_pkg::CL_ERASE
                  || cls == fcx_pkg::CL_WRITE_NV)) begin
                  state <= fcx_pkg::ST_BUSY;
                  busy_is_erase <= (opcode == fcx_pkg::OP_SECTOR_ERASE);
                  susp_sector <= addr[23:fcx_pkg::SECTOR_LSB];
               end
            end
            fcx_pkg::ST_BUSY: begin
               if (OP_DONE) begin
                  state <= fcx_pkg::ST_STANDBY;
               end else if (decide && allow && cls == fcx_pkg::CL_SUSPEND) begin
                  state <= busy_is_erase ? fcx_pkg::ST_SUSPEND_ERASE
                     : fcx_pkg::ST_SUSPEND_SMALL;
               end
            end
            default: begin
               if (decide && allow && cls == fcx_pkg::CL_RESUME) begin
                  state <= fcx_pkg::ST_BUSY;
               end
            end
         endcase
      end
   end

   // Decision pulses and captured command details
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         CMD_ACCEPT <= 1'b0;
         CMD_REJECT <= 1'b0;
         CMD_CLASS <= fcx_pkg::CL_NONE;
         CMD_OPCODE <= 8'h00;
         CMD_ADDR <= 24'h000000;
         READ_UNSAFE <= 1'b0;
      end else if (CE) begin
         CMD_ACCEPT <= frame_end && (xip_frame ? (state != fcx_pkg::ST_BUSY) : allow);
         CMD_REJECT <= frame_end && (xip_frame ? (state == fcx_pkg::ST_BUSY) : !allow);
         if (frame_end) begin
            CMD_CLASS <= xip_frame ? fcx_pkg::CL_READ : cls;
            CMD_OPCODE <= opcode;
            CMD_ADDR <= addr;
            READ_UNSAFE <= (xip_frame || cls == fcx_pkg::CL_READ)
               && state == fcx_pkg::ST_SUSPEND_ERASE && in_susp_sector;
         end
      end
   end

   // ****************************************************************
   // Range check launch and flags
   // ****************************************************************
   logic clear_flags;
   logic start_now;
   logic order_bad;

   assign order_bad = req.end_addr < req.start_addr;
   assign start_now = decide && allow && cls == fcx_pkg::CL_CRC;
   assign clear_flags = decide && allow && opcode == fcx_pkg::OP_CLEAR_FLAGS;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         CRC_START <= 1'b0;
         CRC_REQ <= '0;
         crc_busy <= 1'b0;
      end else if (CE) begin
         CRC_START <= start_now && !order_bad;
         if (start_now && !order_bad) begin
            CRC_REQ <= req;
            crc_busy <= 1'b1;
         end else if (CRC_DONE || reset_fire) begin
            crc_busy <= 1'b0;
         end
      end
   end

   // Hardware set wins over the flag-clear command in the same cycle
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         FLAG_ADDR_ERR <= 1'b0;
         FLAG_CRC_ERR <= 1'b0;
      end else if (CE) begin
         if (start_now && order_bad) begin
            FLAG_ADDR_ERR <= 1'b1;
         end else if (clear_flags) begin
            FLAG_ADDR_ERR <= 1'b0;
         end
         if (crc_busy && CRC_DONE && CRC_RESULT != CRC_REQ.expect_crc) begin
            FLAG_CRC_ERR <= 1'b1;
         end else if (clear_flags) begin
            FLAG_CRC_ERR <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Execute-in-place control
   // ****************************************************************
   logic boot_pending;
   logic quad;

   assign quad = (PROTO_WIDTH == fcx_pkg::W_QUAD);
   // Reset pulse acts at once, except in quad width where it waits for deselect
   assign reset_fire = CE && RESET_PIN_EN && !rst_pin_n && !(quad && cs_low);

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         xip_active <= 1'b0;
         vcr_xip_n <= 1'b1;
         boot_pending <= 1'b1;
      end else if (CE) begin
         if (boot_pending || reset_fire) begin
            boot_pending <= 1'b0;
            xip_active <= (NVCR_XIP_CFG != fcx_pkg::NVCR_XIP_OFF);
            vcr_xip_n <= 1'b1;
         end else if (confirm_now) begin
            if (dq[0]) begin
               xip_active <= 1'b0;
               vcr_xip_n <= 1'b1;
            end else if (xip_active || !vcr_xip_n || BASIC_XIP) begin
               xip_active <= 1'b1;
            end
         end else if (decide && allow && opcode == fcx_pkg::OP_WRITE_VCFG
            && byte_cnt > 5'h01) begin
            vcr_xip_n <= data0[fcx_pkg::VCR_XIP_BIT];
         end
      end
   end

   assign DEV_STATE = state;
   assign XIP_ACTIVE = xip_active;
   assign VCR_XIP_N = vcr_xip_n;
   assign CRC_BUSY = crc_busy;

endmodule

`default_nettype wire

//--- sim/fcx_asserts.sv
// Purpose: Port checker for the flash control block
// Assumes: One clock domain, reset active low
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
// **********
// Checker
// **********
module fcx_asserts (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic CRC_DONE,
   input wire logic [63:0] CRC_RESULT,
   input wire logic CMD_ACCEPT,
   input wire logic CMD_REJECT,
   input wire fcx_pkg::fcx_class_e CMD_CLASS,
   input wire fcx_pkg::fcx_state_e DEV_STATE,
   input wire logic XIP_ACTIVE,
   input wire logic VCR_XIP_N,
   input wire logic CRC_START,
   input wire fcx_pkg::fcx_crc_req_s CRC_REQ,
   input wire logic CRC_BUSY,
   input wire logic FLAG_ADDR_ERR,
   input wire logic FLAG_CRC_ERR
);
   default clocking dc @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);
   sequence s_busy;
      ##[0:1] CRC_BUSY;
   endsequence
   start_ok_a: assert property (CRC_START |-> CMD_ACCEPT && !CMD_REJECT)
      else $error("check launched without accept");
   busy_on_a: assert property (CRC_START |-> s_busy) else $error("check busy missing");
   req_hold_a: assert property (CRC_BUSY && $past(CRC_BUSY) && !CRC_START |-> $stable(CRC_REQ))
      else $error("check request moved");
   addr_err_a: assert property ($rose(FLAG_ADDR_ERR) |-> !CRC_START)
      else $error("bad range launched a check");
   crc_err_a: assert property (CE && CRC_DONE && CRC_BUSY && CRC_RESULT != CRC_REQ.expect_crc
      |=> FLAG_CRC_ERR) else $error("check mismatch not flagged");
   xip_exit_a: assert property ($fell(XIP_ACTIVE) |-> VCR_XIP_N)
      else $error("mode left without volatile bit set");
   susp_src_a: assert property ($changed(DEV_STATE) && DEV_STATE[1]
      |-> $past(DEV_STATE) == fcx_pkg::ST_BUSY) else $error("suspend not from busy");
   read_gate_a: assert property (CMD_ACCEPT && CMD_CLASS == fcx_pkg::CL_READ
      |-> $past(DEV_STATE) != fcx_pkg::ST_BUSY) else $error("read taken while busy");
   nv_gate_a: assert property (CMD_ACCEPT && CMD_CLASS == fcx_pkg::CL_WRITE_NV
      |-> $past(DEV_STATE) == fcx_pkg::ST_STANDBY) else $error("write outside standby");
   reg_read_a: assert property (CMD_REJECT |-> CMD_CLASS != fcx_pkg::CL_READ_REG)
      else $error("status read refused");
endmodule
bind fcx_ctrl fcx_asserts i_chk (.CLK_SYS, .RST_N, .CE, .CRC_DONE, .CRC_RESULT, .CMD_ACCEPT,
   .CMD_REJECT, .CMD_CLASS, .DEV_STATE, .XIP_ACTIVE, .VCR_XIP_N, .CRC_START, .CRC_REQ,
   .CRC_BUSY, .FLAG_ADDR_ERR, .FLAG_CRC_ERR);
`default_nettype wire

//--- sim/fcx_host.sv
// Purpose: Serial host model driving select, clock and data lines
// Assumes: Clock stands low outside frames, 160 ns period
// Notes: Unused and released data lines carry changing values
`timescale 1ns/1ps
`default_nettype none
// **********
// Host
// **********
module fcx_host (
   output logic sck,
   output logic cs_n,
   output logic [3:0] dq,
   input wire fcx_pkg::fcx_width_e width
);
   logic [7:0] fb [0:18];
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      dq = 4'h5;
   end
   task automatic tick;
      #80 sck = 1'b1;
      #80 sck = 1'b0;
   endtask
   task automatic frame(input int n, input int cb);
      int k;
      logic [7:0] t;
      logic [3:0] m;
      k = 1 << width;
      m = 4'((1 << k) - 1);
      cs_n = 1'b0;
      for (int b = 0; b < n; b++) begin
         for (int i = 0; i < 8; i += k) begin
            t = fb[b] << i;
            dq = (4'($urandom) & ~m) | (t[7:4] >> (4 - k));
            tick;
         end
      end
      if (cb >= 0) begin
         dq = {3'($urandom), cb[0]};
         tick;
      end
      #80 cs_n = 1'b1;
      dq = ~dq;
      #80;
   endtask
endmodule
`default_nettype wire

//--- sim/fcx_ctrl_tb.sv
// Purpose: Self-checking bench for the flash control block
// Assumes: Host model drives the serial link
// Notes: Each gated state is reached from a fresh reset
`timescale 1ns/1ps
`default_nettype none
// **********
// Bench
// **********
module fcx_ctrl_tb;
   logic clk, rst_n, ce, rp_n, rp_en, basic, op_done, crc_done, same;
   logic sck, cs_n, acc, rej, unsafe, execute_in_place, vcr_n, cstart, cbusy, faddr, fcrc;
   logic acc_s, rej_s, start_s, clr;
   logic [3:0] dq;
   logic [2:0] nvcr;
   logic [7:0] opc;
   logic [7:0] ops [6];
   logic [23:0] addr, a;
   logic [31:0] s0, s1;
   logic [63:0] crc_res, e;
   fcx_pkg::fcx_width_e width;
   fcx_pkg::fcx_class_e cls;
   fcx_pkg::fcx_state_e st;
   fcx_pkg::fcx_crc_req_s req;
   int fails, checks_done;
   fcx_host i_host (.sck(sck), .cs_n(cs_n), .dq(dq), .width(width));
   fcx_ctrl i_dut (.CLK_SYS(clk), .RST_N(rst_n), .CE(ce), .SCK(sck), .CS_N(cs_n),
      .DQ_IN(dq), .RESET_PIN_N(rp_n), .RESET_PIN_EN(rp_en), .BASIC_XIP(basic),
      .NVCR_XIP_CFG(nvcr), .PROTO_WIDTH(width), .OP_DONE(op_done), .CRC_DONE(crc_done),
      .CRC_RESULT(crc_res), .CMD_ACCEPT(acc), .CMD_REJECT(rej), .CMD_CLASS(cls),
      .CMD_OPCODE(opc), .CMD_ADDR(addr), .READ_UNSAFE(unsafe), .DEV_STATE(st),
      .XIP_ACTIVE(execute_in_place), .VCR_XIP_N(vcr_n), .CRC_START(cstart), .CRC_REQ(req),
      .CRC_BUSY(cbusy), .FLAG_ADDR_ERR(faddr), .FLAG_CRC_ERR(fcrc));
   always @(posedge clk) begin
      if (clr) begin
         {acc_s, rej_s, start_s} <= 3'b000;
      end else begin
         acc_s <= acc_s | acc;
         rej_s <= rej_s | rej;
         start_s <= start_s | cstart;
      end
   end
   task automatic chk(input logic [127:0] v, input logic [127:0] x);
      checks_done++;
      if (v !== x) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, v, x);
      end
   endtask
   task automatic end_sim;
      if (fails == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic rst;
      rst_n = 1'b0;
      wt(12);
      rst_n = 1'b1;
      wt(6);
   endtask
   task automatic put(input logic [7:0] op, input logic [23:0] ad);
      i_host.fb[0] = op;
      {i_host.fb[1], i_host.fb[2], i_host.fb[3]} = ad;
   endtask
   task automatic send(input int n, input int cb, input logic [1:0] r);
      clr = 1'b1;
      wt(1);
      clr = 1'b0;
      i_host.frame(n, cb);
      chk({rej_s, acc_s}, r);
   endtask
   task automatic go(input int s);
      rst;
      put(s == 3 ? 8'hd8 : 8'h02, a);
      if (s > 0) send(5, -1, 2'b01);
      put(8'h75, a);
      if (s > 1) send(5, -1, 2'b01);
      chk(st, s);
   endtask
   task automatic crc(input logic [31:0] b0, input logic [31:0] b1, input int bad,
      input logic [1:0] r);
      {i_host.fb[0], i_host.fb[1], i_host.fb[2]} = 24'h9b27fe;
      for (int i = 0; i < 8; i++) i_host.fb[3 + i] = e[8 * i +: 8];
      for (int i = 0; i < 4; i++) {i_host.fb[15 + i], i_host.fb[11 + i]} = {b1[8 * i +: 8],
         b0[8 * i +: 8]};
      if (bad > 0) i_host.fb[bad] = ~i_host.fb[bad];
      send(19, -1, r);
   endtask
   task automatic pin(input logic en);
      rp_en = en;
      rp_n = 1'b0;
      wt(10);
      rp_n = 1'b1;
      wt(4);
   endtask
   function automatic logic ok(input int s, input logic [7:0] op, input logic sm);
      case (op)
         8'h03, 8'h06: return s != 1;
         8'h70: return 1'b1;
         8'h02: return s == 0 || (s == 3 && !sm);
         8'h75: return s == 1;
         default: return s == 0;
      endcase
   endfunction
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #380us;
      fails++;
      end_sim;
   end
   initial begin
      void'($urandom(32'hd72e));
      {rst_n, ce, rp_n, rp_en, basic, op_done, crc_done} = 7'b0110000;
      clr = 1'b1;
      {fails, checks_done} = 64'h0;
      {nvcr, crc_res, a} = {3'h7, 64'h0, 24'h0};
      width = fcx_pkg::W_SINGLE;
      ops = '{8'h03, 8'h70, 8'h02, 8'h01, 8'h06, 8'h75};
      i_host.fb[4] = 8'h5a;
      rst;
      chk({st, execute_in_place, vcr_n}, 4'b0001);
      e = {$urandom, $urandom};
      s0 = {1'b0, 31'($urandom)};
      s1 = s0 + 32'($urandom_range(255));
      crc(s0, s1, 0, 2'b01);
      chk({start_s, cbusy}, 2'b11);
      chk(req, {e, s0, s1});
      crc_res = e ^ 64'h1;
      wt(1);
      crc_done = 1'b1;
      wt(1);
      crc_done = 1'b0;
      wt(2);
      chk({fcrc, cbusy}, 2'b10);
      crc(s0 + 1, s0, 0, 2'b01);
      chk({start_s, faddr}, 2'b01);
      crc(s0, s1, $urandom_range(2, 1), 2'b10);
      for (int s = 0; s < 4; s++)
         for (int o = 0; o < 6; o++) begin
            {a, same} = 25'($urandom);
            width = fcx_pkg::fcx_width_e'($urandom_range(2, 1));
            go(s);
            put(ops[o], same ? a : a ^ 24'h010000);
            send(5, -1, {~ok(s, ops[o], same), ok(s, ops[o], same)});
            if (s == 3 && o == 0) chk(unsafe, same);
         end
      width = fcx_pkg::W_SINGLE;
      rst;
      {i_host.fb[0], i_host.fb[1]} = 16'h81f7;
      send(2, -1, 2'b01);
      chk(vcr_n, 1'b0);
      put(8'h0b, a);
      send(4, 0, 2'b01);
      chk(execute_in_place, 1'b1);
      for (int w = 0; w < 3; w++) begin
         width = fcx_pkg::fcx_width_e'(w);
         a = 24'($urandom);
         {i_host.fb[0], i_host.fb[1], i_host.fb[2]} = a;
         send(3, 0, 2'b01);
         chk({execute_in_place, cls, opc, addr}, {1'b1, fcx_pkg::CL_READ, 8'h0b, a});
      end
      send(3, 1, 2'b01);
      chk({execute_in_place, vcr_n}, 2'b01);
      width = fcx_pkg::W_SINGLE;
      basic = 1'b1;
      rst;
      put(8'h0b, a);
      send(4, 0, 2'b01);
      chk({execute_in_place, vcr_n}, 2'b11);
      basic = 1'b0;
      nvcr = 3'($urandom_range(6));
      rst;
      chk(execute_in_place, 1'b1);
      send(3, 1, 2'b01);
      chk(execute_in_place, 1'b0);
      pin(1'b0);
      chk(execute_in_place, 1'b0);
      pin(1'b1);
      chk({execute_in_place, vcr_n}, 2'b11);
      ce = 1'b0;
      send(3, 1, 2'b00);
      chk(execute_in_place, 1'b1);
      ce = 1'b1;
      end_sim;
   end
endmodule
`default_nettype wire
